//--- hdl/pflc_top.sv
/*
  power-fail supervision: debounce, interrupt event, host bus lockout
  with optional delayed access, standby isolation and supply flags.
  assumes supply comparators arrive as asynchronous levels; the host
  register logic outside supplies the enable and control bits.
*/
// What the document requires
// RULE_01 - low power-fail input debounced before acting
// RULE_02 - debounced failure raises power-fail interrupt event
// RULE_03 - without delay, lock bus after debounce
// RULE_04 - with delay, keep bus 480 us
// RULE_05 - clearing delay enable locks bus immediately
// RULE_06 - access held over 30 us forces lockout
// RULE_07 - standby follows supply comparison, not input
// RULE_08 - lockout isolates bus; standby isolates more
// RULE_09 - mode bits keep timers, interrupts after failure; only timer_pf_run is used, int_pf_run is ignored
// RULE_10 - unlock only after high-level debounce
// RULE_11 - masked interrupt still locks; off in standby
// RULE_12 - power-up sets osc-fail, clears start bit
// RULE_13 - osc-fail stays until clock started
// RULE_14 - host writes D6 low for battery mode
// RULE_15 - low battery only on main supply, enabled
// RULE_16 - time-save bit clears at battery switch
// RULE_17 - host sets single-supply bit, disables interrupt
// RULE_18 - host sets interrupt enable bit
// RULE_19 - status flag mirrors failure, not host-clearable
// RULE_20 - windows timed by internal counters
// RULE_21 - locked out: data high-z, writes ignored
`include "pflc_regs.svh"
module pflc_top
  import pflc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       power_loss_n_input,
  input  wire logic       vbb_above_vcc,
  input  wire logic       battery_low_cmp,
  input  wire pflc_bus_t  host_bus,
  input  wire logic [7:0] host_data_in,
  input  wire logic       timer0_gate_in,
  input  wire logic       timer1_gate_in,
  input  wire logic       delay_enable,
  input  wire logic       pf_int_enable,
  input  wire logic       timer_pf_run,
  input  wire logic       int_pf_run,
  input  wire logic       clock_start_set,
  input  wire logic       tsave_set,
  input  wire logic       tsave_clr,
  input  wire logic       irq_req,
  input  wire logic       host_dout_en,
  output logic            bus_locked,
  output logic            pf_irq_pulse,
  output pflc_stat_t      status,
  output logic            clock_start,
  output logic            host_strobe_ok,
  output logic            host_write_ok,
  output logic            host_data_oe,
  output logic [7:0]      host_data_lat,
  output logic            timer0_gate_q,
  output logic            timer1_gate_q,
  output logic            timers_run,
  output logic            irq_out_od,
  output logic            timer_outs_od
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] sync_in;

  assign sync_in = {power_loss_n_input, vbb_above_vcc, battery_low_cmp,
                    timer0_gate_in, timer1_gate_in};

  // two stages for every asynchronous level
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sync1_r <= 5'h1f;
      sync2_r <= 5'h1f;
    end
    else
    begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
    end
  end

  logic pfn_s;
  logic standby_s;
  logic lowb_s;
  assign pfn_s     = sync2_r[4];
  assign standby_s = sync2_r[3];
  assign lowb_s    = sync2_r[2];

  // ****************************************************************
  // debounce
  // ****************************************************************
  logic pfn_deb;

  pflc_filter #(
    .DEB_CYC (`PFLC_DEB_CYC)
  ) u_deb (
    .mclk  (mclk),
    .rst_b (rst_b),
    .din   (pfn_s),
    .dout  (pfn_deb)
  );

  logic pf_fail;
  assign pf_fail = !pfn_deb;  // [RULE_01]

  // ****************************************************************
  // lockout sequencer
  // ****************************************************************
  pflc_state_t st_r;
  pflc_state_t st_nxt;
  logic [16:0] dly_r;
  logic [16:0] dly_nxt;
  logic [12:0] grd_r;
  logic [12:0] grd_nxt;
  logic        cs_at_fail_r;
  logic        cs_at_fail_nxt;
  logic        fail_d_r;
  logic        access;

  assign access = !host_bus.cs_n && (!host_bus.rd_n || !host_bus.wr_n);

  // sequencer next state; guard counts a continuous access if chip select was low at failure
  always_comb
  begin
    st_nxt         = st_r;
    dly_nxt        = dly_r;
    grd_nxt        = 13'h0000;
    cs_at_fail_nxt = cs_at_fail_r;
    case (st_r)
      PFLC_RUN:
      begin
        dly_nxt = 17'h00000;
        if (pf_fail)
        begin
          cs_at_fail_nxt = !host_bus.cs_n;
          if (delay_enable)
            st_nxt = PFLC_DELAY;   // [RULE_04]
          else
            st_nxt = PFLC_LOCK;    // [RULE_03]
        end
      end
      PFLC_DELAY:
      begin
        dly_nxt = dly_r + 17'h00001; // [RULE_20]
        if (cs_at_fail_r && access)
          grd_nxt = grd_r + 13'h0001;
        if (!pf_fail)
          st_nxt = PFLC_RUN;
        else if (!delay_enable)
          st_nxt = PFLC_LOCK;      // [RULE_05]
        else if (dly_r >= 17'(`PFLC_DELAY_CYC - 1))
          st_nxt = PFLC_LOCK;      // [RULE_04]
        else if (grd_r >= 13'(`PFLC_GUARD_CYC - 1))
          st_nxt = PFLC_LOCK;      // [RULE_06]
      end
      PFLC_LOCK:
      begin
        cs_at_fail_nxt = 1'b0;
        if (!pf_fail)
          st_nxt = PFLC_RUN;       // [RULE_10]
      end
      default:
        st_nxt = PFLC_RUN;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st_r         <= PFLC_RUN;
      dly_r        <= 17'h00000;
      grd_r        <= 13'h0000;
      cs_at_fail_r <= 1'b0;
      fail_d_r     <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      dly_r        <= dly_nxt;
      grd_r        <= grd_nxt;
      cs_at_fail_r <= cs_at_fail_nxt;
      fail_d_r     <= pf_fail;
    end
  end

  // standby locks the bus too, whatever the input says
  assign bus_locked = (st_r == PFLC_LOCK) || standby_s; // [RULE_08]

  // ****************************************************************
  // pin isolation
  // ****************************************************************
  // strobes and write data are simply refused while locked
  assign host_strobe_ok = !bus_locked && !host_bus.cs_n;     // [RULE_08]
  assign host_write_ok  = host_strobe_ok && !host_bus.wr_n;  // [RULE_21]
  assign host_data_oe   = host_dout_en && host_strobe_ok
                          && !host_bus.rd_n;                 // [RULE_21]
  assign irq_out_od     = standby_s;                         // [RULE_08]
  assign timer_outs_od  = standby_s;

  // ****************************************************************
  // flags and registered outputs
  // ****************************************************************
  logic       irq_r;
  logic       irq_nxt;
  logic       osc_r;
  logic       osc_nxt;
  logic       start_r;
  logic       start_nxt;
  logic       tsave_r;
  logic       tsave_nxt;
  logic       lowb_r;
  logic       lowb_nxt;
  logic       g0_r;
  logic       g1_r;
  logic [7:0] dlat_r;
  logic [7:0] dlat_nxt;

  // interrupt event on the debounced edge; masked and in standby silent
  always_comb
  begin
    irq_nxt   = pf_fail && !fail_d_r && pf_int_enable
                && !standby_s;                 // [RULE_02] [RULE_11]
    osc_nxt   = osc_r;
    start_nxt = start_r;
    if (clock_start_set && host_write_ok)
    begin
      start_nxt = 1'b1;
      osc_nxt   = 1'b0;                        // [RULE_13]
    end
    tsave_nxt = tsave_r;
    if (tsave_set && host_write_ok)
      tsave_nxt = 1'b1;
    else if (tsave_clr && host_write_ok)
      tsave_nxt = 1'b0;
    if (standby_s)
      tsave_nxt = 1'b0;                        // [RULE_16]
    lowb_nxt = lowb_s && !standby_s && pf_int_enable; // [RULE_15]
    dlat_nxt = host_write_ok ? host_data_in : dlat_r; // [RULE_21]
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      irq_r   <= 1'b0;
      osc_r   <= `PFLC_OSC_FAIL_RST;           // [RULE_12]
      start_r <= 1'b0;                         // [RULE_12]
      tsave_r <= `PFLC_TSAVE_RST;
      lowb_r  <= 1'b0;
      g0_r    <= 1'b0;
      g1_r    <= 1'b0;
      dlat_r  <= 8'h00;
    end
    else
    begin
      irq_r   <= irq_nxt;
      osc_r   <= osc_nxt;
      start_r <= start_nxt;
      tsave_r <= tsave_nxt;
      lowb_r  <= lowb_nxt;
      g0_r    <= sync2_r[1] && !standby_s;     // [RULE_08]
      g1_r    <= sync2_r[0] && !standby_s;
      dlat_r  <= dlat_nxt;
    end
  end

  assign pf_irq_pulse     = irq_r;
  assign status.pf_status = pf_fail;           // [RULE_19]
  assign status.osc_fail  = osc_r;
  assign status.low_batt  = lowb_r;
  assign status.tsave_en  = tsave_r;
  assign status.standby   = standby_s;         // [RULE_07]
  assign clock_start      = start_r;
  assign host_data_lat    = dlat_r;
  assign timer0_gate_q    = g0_r;
  assign timer1_gate_q    = g1_r;
  // timer_pf_run alone decides whether timers run on after a failure
  assign timers_run       = !pf_fail || timer_pf_run;     // [RULE_09]

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_fail_rise;
    pf_fail && !fail_d_r;
  endsequence

  a_nodelay_lock: assert property (@(posedge mclk) // [RULE_03]
    disable iff (!rst_b) (s_fail_rise and !delay_enable) |=> bus_locked)
    else $error("no lockout after failure without delay");

  a_delay_open: assert property (@(posedge mclk) // [RULE_04]
    disable iff (!rst_b) (st_r == PFLC_RUN) && pf_fail && delay_enable
    && !standby_s |=> !bus_locked)
    else $error("bus locked at start of delay window");

  a_early_clear: assert property (@(posedge mclk) // [RULE_05]
    disable iff (!rst_b) (st_r == PFLC_DELAY) && pf_fail && !delay_enable
    |=> st_r == PFLC_LOCK)
    else $error("delay clear did not lock");

  a_irq_mask: assert property (@(posedge mclk) // [RULE_11]
    disable iff (!rst_b) pf_irq_pulse |-> $past(pf_int_enable))
    else $error("interrupt issued while masked");

  a_lock_strobe: assert property (@(posedge mclk) // [RULE_21]
    disable iff (!rst_b) bus_locked |-> !host_strobe_ok && !host_data_oe)
    else $error("bus active while locked");

  a_stay_locked: assert property (@(posedge mclk) // [RULE_10]
    disable iff (!rst_b) (st_r == PFLC_LOCK) && pf_fail |=> st_r == PFLC_LOCK)
    else $error("unlocked while failure stands");

  a_tsave_clr: assert property (@(posedge mclk) // [RULE_16]
    disable iff (!rst_b) standby_s |=> !status.tsave_en)
    else $error("time save survived standby");

  // the flag is registered from the previous cycle's supply and enable
  a_lowb_main: assert property (@(posedge mclk) // [RULE_15]
    disable iff (!rst_b)
    status.low_batt |-> !$past(standby_s) && $past(pf_int_enable))
    else $error("low battery set outside main supply");

  // the flag may only drop in the cycle the start bit rises
  a_osc_hold: assert property (@(posedge mclk) // [RULE_13]
    disable iff (!rst_b) $fell(status.osc_fail) |-> $rose(clock_start))
    else $error("osc fail cleared without start");

endmodule // pflc_top

//--- hdl/pflc_regs.svh
/*
  timing and layout constants for the power-fail lockout control block.
  assumes a 200 MHz mclk; included by the top module only, not by the package.
*/
`ifndef PFLC_REGS_SVH
`define PFLC_REGS_SVH

// clock period in ps (5 ns)
`define PFLC_CLK_PS          32'd5000
// debounce window, least and longest, in ns
`define PFLC_DEB_MIN_NS      32'd30000
`define PFLC_DEB_MAX_NS      32'd63000
// delayed-access window in ns
`define PFLC_DELAY_NS        32'd480000
// stuck-access guard in ns
`define PFLC_GUARD_NS        32'd30000
// cycle counts: least times round up
`define PFLC_DEB_CYC   ((`PFLC_DEB_MIN_NS*32'd1000+`PFLC_CLK_PS-32'd1)/`PFLC_CLK_PS)
`define PFLC_DELAY_CYC ((`PFLC_DELAY_NS*32'd1000+`PFLC_CLK_PS-32'd1)/`PFLC_CLK_PS)
`define PFLC_GUARD_CYC ((`PFLC_GUARD_NS*32'd1000+`PFLC_CLK_PS-32'd1)/`PFLC_CLK_PS)
// reset values of flags
`define PFLC_OSC_FAIL_RST    1'b1
`define PFLC_TSAVE_RST       1'b0

`endif

//--- hdl/pflc_pkg.sv
/*
  types for the power-fail lockout control block.
  assumes nothing beyond the constants header.
*/
package pflc_pkg;

  // lockout sequencer states, one-hot
  typedef enum logic [3:0] {
    PFLC_RUN   = 4'h1,
    PFLC_DEB   = 4'h2,
    PFLC_DELAY = 4'h4,
    PFLC_LOCK  = 4'h8
  } pflc_state_t;

  // status toward the host register logic
  typedef struct packed {
    logic pf_status;
    logic osc_fail;
    logic low_batt;
    logic tsave_en;
    logic standby;
  } pflc_stat_t;

  // host-side bus strobes as seen by the block
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } pflc_bus_t;

endpackage

//--- hdl/pflc_filter.sv
/*
  level filter: output follows a synchronised input only after it has
  stood at the new level for DEB_CYC cycles; restarts on any change.
  assumes the input is already on mclk.
*/
module pflc_filter
  import pflc_pkg::*;
#(
  parameter int unsigned DEB_CYC = 6000
)(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        out_r;
  logic        out_nxt;

  // count while input differs from output, restart when they agree
  always_comb
  begin
    cnt_nxt = 16'h0000;
    out_nxt = out_r;
    if (din != out_r)
    begin
      if (cnt_r >= 16'(DEB_CYC - 1))
        out_nxt = din;             // [RULE_01] [RULE_10]
      else
        cnt_nxt = cnt_r + 16'h0001; // [RULE_20]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cnt_r <= 16'h0000;
      out_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;

endmodule // pflc_filter

//--- verification/pflc_host_model.sv
/*
  host processor partner: makes read and write strobes on the bus.
  assumes the bench steers it through acc_req, acc_wr and acc_data.
*/
// ********************
// host bus model
// ********************
module pflc_host_model
  import pflc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       acc_req,
  input  wire logic       acc_wr,
  input  wire logic [7:0] acc_data,
  output pflc_bus_t       host_bus,
  output logic      [7:0] host_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_bus = 3'h7;
  initial host_data_in = 8'h00;
  // strobes move just after an edge and stand while requested
  always @(posedge mclk)
  begin
    host_bus <= {!acc_req, !(acc_req && !acc_wr), !(acc_req && acc_wr)};
    // a released bus floats: toggle so no stale byte looks valid
    host_data_in <= acc_req ? acc_data : ~host_data_in;
  end
endmodule // pflc_host_model

//--- verification/tb_power_fail_lockout_control.sv
/*
  self-checking bench: glitches, lockout with and without delayed
  access, stuck-access guard, standby isolation and supply flags.
  assumes the fixed counts of pflc_top at a 200 MHz mclk.
*/
// ********************
// bench top
// ********************
module tb_power_fail_lockout_control
  import pflc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DMIN = 30000 / 5;
  localparam int DMAX = 63000 / 5;
  localparam int LIMIT = 90000;
  logic        mclk, rst_b, power_loss_n_input, vbb_above_vcc;
  logic        battery_low_cmp, timer0_gate_in, timer1_gate_in;
  logic        delay_enable, pf_int_enable, timer_pf_run, int_pf_run;
  logic        clock_start_set, tsave_set, tsave_clr, irq_req;
  logic        host_dout_en, bus_locked, pf_irq_pulse, clock_start;
  logic        host_strobe_ok, host_write_ok, host_data_oe, w_ok, r_oe, s_ok;
  logic        timer0_gate_q, timer1_gate_q, timers_run, irq_out_od;
  logic        timer_outs_od, acc_req, acc_wr;
  logic [7:0]  host_data_in, host_data_lat, acc_data, d;
  logic [15:0] seed;
  pflc_bus_t   host_bus;
  pflc_stat_t  status;
  int          n_mismatch = 0, checked = 0, cyc = 0, irqs = 0, n;

  pflc_top pflc_top_i (
    .mclk, .rst_b, .power_loss_n_input, .vbb_above_vcc, .battery_low_cmp,
    .host_bus, .host_data_in, .timer0_gate_in, .timer1_gate_in,
    .delay_enable, .pf_int_enable, .timer_pf_run, .int_pf_run,
    .clock_start_set, .tsave_set, .tsave_clr, .irq_req, .host_dout_en,
    .bus_locked, .pf_irq_pulse, .status, .clock_start, .host_strobe_ok,
    .host_write_ok, .host_data_oe, .host_data_lat, .timer0_gate_q,
    .timer1_gate_q, .timers_run, .irq_out_od, .timer_outs_od
  );
  pflc_host_model pflc_host_model_i (
    .mclk, .acc_req, .acc_wr, .acc_data, .host_bus, .host_data_in
  );

  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // hang guard and interrupt event count
  always @(posedge mclk)
  begin
    cyc++;
    if (pf_irq_pulse === 1'b1)
      irqs++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // inputs always move 1 ns after the edge
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // one access; accept flags sampled while the strobes stand
  task automatic acc(input logic wr, input logic [7:0] v);
    acc_req = 1'b1;
    acc_wr = wr;
    acc_data = v;
    tick(2);
    w_ok = host_write_ok;
    s_ok = host_strobe_ok;
    r_oe = host_data_oe;
    acc_req = 1'b0;
    tick(2);
  endtask
  // bounded wait for the lock level; n holds cycles spent
  task automatic wait_lk(input logic lv, input int lim);
    n = 0;
    while (bus_locked !== lv && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {vbb_above_vcc, battery_low_cmp, timer0_gate_in, timer1_gate_in} = 4'h0;
    {delay_enable, clock_start_set, tsave_set, tsave_clr, irq_req} = 5'h00;
    {acc_req, acc_wr, acc_data, host_dout_en} = 11'h000;
    {rst_b, pf_int_enable, timer_pf_run, int_pf_run} = 4'h3;
    power_loss_n_input = 1'b1;
    seed = 16'h5cca;
    tick(10);
    rst_b = 1'b1;
    tick(3);
    chk({status.osc_fail, clock_start, bus_locked}, 3'h4);
    // random writes; the flag survives writes that do not start the clock
    repeat (4)
    begin
      seed = lfsr(seed);
      acc(1'b1, seed[7:0] & 8'hbf);
      chk(host_data_lat, seed[7:0] & 8'hbf);
      chk({s_ok, w_ok}, 2'h3);
      chk(status.osc_fail, 1);
    end
    clock_start_set = 1'b1;
    acc(1'b1, 8'h80);
    clock_start_set = 1'b0;
    chk({clock_start, status.osc_fail}, 2'h2);
    host_dout_en = 1'b1;
    acc(1'b0, 8'h00);
    chk(r_oe, 1);
    // supply flags and standby isolation
    pf_int_enable = 1'b1;
    battery_low_cmp = 1'b1;
    tsave_set = 1'b1;
    acc(1'b1, 8'h00);
    tsave_set = 1'b0;
    chk({status.low_batt, status.tsave_en}, 2'h3);
    {timer0_gate_in, timer1_gate_in} = 2'h3;
    vbb_above_vcc = 1'b1;
    tick(6);
    chk({bus_locked, irq_out_od, timer_outs_od}, 3'h7);
    chk({status.standby, status.pf_status}, 2'h2);
    chk({timer0_gate_q, timer1_gate_q, status.low_batt}, 0);
    chk(status.tsave_en, 0);
    vbb_above_vcc = 1'b0;
    tick(6);
    chk({bus_locked, timer0_gate_q, timer1_gate_q, irq_out_od,
         timer_outs_od}, 5'h0c);
    pf_int_enable = 1'b0;
    tick(6);
    chk(status.low_batt, 0);
    {pf_int_enable, battery_low_cmp} = 2'h2;
    tsave_set = 1'b1;
    acc(1'b1, 8'h00);
    tsave_set = 1'b0;
    // short drops, one just under the debounce window
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      power_loss_n_input = 1'b0;
      tick(i == 3 ? DMIN - 10 : 1 + int'(seed[11:0]));
      power_loss_n_input = 1'b1;
      tick(8);
      chk({bus_locked, status.pf_status}, 0);
    end
    chk(irqs, 0);
    // failure without delayed access
    timer_pf_run = 1'b0;
    power_loss_n_input = 1'b0;
    wait_lk(1'b1, 2 * DMAX);
    chk(n >= DMIN && n <= DMAX, 1);
    tick(3);
    chk(irqs, 1);
    chk({status.pf_status, status.tsave_en}, 2'h3);
    chk(timers_run, 0);
    d = host_data_lat;
    acc(1'b1, ~d);
    chk({s_ok, w_ok, host_data_lat}, {2'b00, d});
    acc(1'b0, 8'h00);
    chk(r_oe, 0);
    power_loss_n_input = 1'b1;
    tick(DMIN - 10);
    chk(bus_locked, 1);
    wait_lk(1'b0, DMAX);
    chk(n <= DMAX - DMIN + 10, 1);
    chk(status.pf_status, 0);
    // delayed access with the interrupt masked, ended by the host
    {pf_int_enable, delay_enable, timer_pf_run} = 3'h3;
    power_loss_n_input = 1'b0;
    tick(DMAX + 20);
    chk({bus_locked, status.pf_status}, 2'h1);
    seed = lfsr(seed);
    acc(1'b1, seed[7:0]);
    chk(host_data_lat, seed[7:0]);
    chk(timers_run, 1);
    delay_enable = 1'b0;
    wait_lk(1'b1, 8);
    chk(n <= 3, 1);
    chk(irqs, 1);
    power_loss_n_input = 1'b1;
    wait_lk(1'b0, 2 * DMAX);
    // access held across detection trips the guard
    delay_enable = 1'b1;
    acc_req = 1'b1;
    acc_wr = 1'b1;
    tick(2);
    power_loss_n_input = 1'b0;
    wait_lk(1'b1, 3 * DMAX);
    chk(n >= 2 * DMIN && n <= 2 * DMAX, 1);
    acc_req = 1'b0;
    delay_enable = 1'b0;
    power_loss_n_input = 1'b1;
    wait_lk(1'b0, 2 * DMAX);
    chk(bus_locked, 0);
    final_report();
  end
endmodule // tb_power_fail_lockout_control
